// ### rtl/fpp_regs.svh
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH

// register offsets (byte addresses)
`define FPP_REG_SR1        8'h00
`define FPP_REG_SR2        8'h04
`define FPP_REG_SR3        8'h08
`define FPP_REG_PTR        8'h0c
`define FPP_REG_CTRL       8'h10
`define FPP_REG_FILL       8'h14

// reset (delivery) values
`define FPP_SR1_RST        8'h00
`define FPP_SR2_RST        8'h04
`define FPP_SR3_RST        8'h70
`define FPP_ERASED_BYTE    8'hff

// status and control register field positions
`define FPP_SR1_BUSY       0
`define FPP_SR1_WEL        1
`define FPP_SR1_TB         5
`define FPP_SR1_STATUS_LOCK_LOW       7
`define FPP_SR2_STATUS_LOCK_HIGH       0
`define FPP_CTRL_SUSP      0
`define FPP_CTRL_BUSY      1

// set-protection address fields
`define FPP_A_SCHEME       10
`define FPP_A_ALL          11
`define FPP_A_PTR_LSB      12

// array top addresses
`define FPP_AMAX_64        24'h7fffff
`define FPP_AMAX_32        24'h3fffff

// serial opcodes
`define FPP_OP_WREN        8'h06
`define FPP_OP_WRDI        8'h04
`define FPP_OP_SETPROT     8'h39
`define FPP_OP_RDSR3       8'h33
`define FPP_OP_PROG        8'h02
`define FPP_OP_SE          8'h20
`define FPP_OP_BE          8'hd8

// frame lengths in serial clocks
`define FPP_BITS_OPCODE    6'h08
`define FPP_BITS_ADDR      6'h20
`define FPP_BITS_DATA      6'h28
`define FPP_BITS_WRAP      6'h2f

// timing
`define FPP_NV_TIME_NS     10000
`define FPP_CLK_MHZ        250

`endif

// ### rtl/fpp_pkg.sv
package fpp_pkg;

  typedef enum logic {
    FPP_NV_IDLE,
    FPP_NV_WRITE
  } fpp_nv_state_t;

  typedef logic [7:0] fpp_opcode_t;

endpackage

// ### rtl/fpp_top.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// - exactly one scheme active, block protection or pointer protection.
// - set-protection is opcode 39h plus three address bytes.
// - scheme bit set selects block protection, pointer bits ignored.
// - scheme bit clear selects pointer protection; low ten bits ignored.
// - 32-Mbit variant stores A21-A12, ignores A23-A22.
// - 64-Mbit variant stores A22-A12, ignores A23.
// - protect-all bit set protects every sector.
// - pointer sector itself is unprotected unless the protect-all bit is set.
// - top-bottom bit of status one picks growth direction.
// - top-bottom 0: pointer sector and below unprotected, above protected.
// - top-bottom 1: pointer sector and above unprotected, below protected.
// - top address 7FFFFFh on 64-Mbit, 3FFFFFh on 32-Mbit.
// - status lock bits block command 39h while locking.
// - command 39h ignored during program or erase suspend.
// - command 33h returns status three, pointer high, pointer middle.
// - block erase rejected over pointer sector, edge sector exceptions.
// - array and security registers read erased FFh at delivery.
// - status registers deliver as 00h, 04h, 70h.
// - busy set during pointer update; write enable cleared at end.
`include "fpp_regs.svh"

module fpp_top #(
  parameter bit P_MBIT64 = 1'b1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_si,
  input  wire logic        i_wp_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_so,
  output logic             o_so_oe,
  output logic             o_op_start,
  output logic             o_op_reject,
  output logic      [7:0]  o_op_code,
  output logic      [23:0] o_op_addr,
  output logic             o_block_prot_en,
  output logic             o_ptr_prot_en,
  output logic             o_busy
);

  localparam int          NV_CYC   = (`FPP_NV_TIME_NS * `FPP_CLK_MHZ + 999) / 1000;
  localparam logic [10:0] PTR_MASK = P_MBIT64 ? 11'h7ff : 11'h3ff;
  localparam logic [23:0] AMAX     = P_MBIT64 ? `FPP_AMAX_64 : `FPP_AMAX_32;
  localparam logic [3:0]  PIN_RST  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {wp_n, si, sck, cs_n}

  logic [3:0] pin_in;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_lvl;
  assign pin_in = {i_wp_n, i_si, i_sck, i_cs_n};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          pin_s1[g]  <= PIN_RST[g];
          pin_s2[g]  <= PIN_RST[g];
          pin_s3[g]  <= PIN_RST[g];
          pin_lvl[g] <= PIN_RST[g];
        end else begin
          pin_s1[g] <= pin_in[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g]) begin
            pin_lvl[g] <= pin_s3[g];
          end
        end
      end
    end
  endgenerate

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_low;
  logic si_bit;
  logic wp_low;

  assign sck_rise = pin_s2[1] & pin_s3[1] & ~pin_lvl[1];
  assign sck_fall = ~pin_s2[1] & ~pin_s3[1] & pin_lvl[1];
  assign cs_rise  = pin_s2[0] & pin_s3[0] & ~pin_lvl[0];
  assign cs_low   = ~pin_lvl[0];
  assign si_bit   = pin_s3[2];
  assign wp_low   = ~pin_lvl[3];

  ////////////////////////////////////////////////////////////////////////////
  // serial receive

  logic [31:0]         rx;
  logic [5:0]          bit_cnt;
  fpp_pkg::fpp_opcode_t opcode;
  logic [23:0]         addr_q;
  logic [7:0]          next_byte;
  assign next_byte = {rx[6:0], si_bit};
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !cs_low) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise) begin
      if (bit_cnt == `FPP_BITS_WRAP) begin
        bit_cnt <= `FPP_BITS_DATA;
      end else begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx     <= 32'h0000_0000;
      opcode <= 8'h00;
      addr_q <= 24'h00_0000;
    end else if (sck_rise && cs_low) begin
      rx <= {rx[30:0], si_bit};
      if (bit_cnt == `FPP_BITS_OPCODE - 6'h01) begin
        opcode <= next_byte;
      end
      if (bit_cnt == `FPP_BITS_ADDR - 6'h01) begin
        addr_q <= {rx[22:0], si_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and protection state

  logic [7:2]  sr1_hi;
  logic [7:0]  sr2;
  logic [7:0]  sr3;
  logic        write_enable_latch;
  logic        suspend;
  logic        prot_all;
  logic [10:0] ptr;
  logic        tb;
  logic        locked;
  logic [23:0] ptr_addr;
  logic [7:0]  sr1;
  assign tb       = sr1_hi[`FPP_SR1_TB];
  assign locked   = sr2[`FPP_SR2_STATUS_LOCK_HIGH] | (sr1_hi[`FPP_SR1_STATUS_LOCK_LOW] & wp_low);
  assign ptr_addr = {1'b0, ptr, prot_all, o_block_prot_en, 10'h000};
  assign sr1      = {sr1_hi, write_enable_latch, o_busy};

  ////////////////////////////////////////////////////////////////////////////
  // command decode at chip-select rise

  logic byte_ok;
  logic frame_addr;
  logic setprot_go;
  logic is_prog;
  logic is_erase;
  logic arr_go;
  logic wren_go;
  logic wrdi_go;
  assign byte_ok    = bit_cnt[2:0] == 3'h0;
  assign frame_addr = bit_cnt == `FPP_BITS_ADDR;
  assign setprot_go = cs_rise && opcode == `FPP_OP_SETPROT && frame_addr
                      && write_enable_latch && !locked && !suspend && !o_busy;
  assign is_prog    = opcode == `FPP_OP_PROG && bit_cnt >= `FPP_BITS_DATA && byte_ok;
  assign is_erase   = (opcode == `FPP_OP_SE || opcode == `FPP_OP_BE) && frame_addr;
  assign arr_go     = cs_rise && (is_prog || is_erase) && write_enable_latch && !o_busy && !suspend;
  assign wren_go    = cs_rise && opcode == `FPP_OP_WREN && bit_cnt == `FPP_BITS_OPCODE && !o_busy;
  assign wrdi_go    = cs_rise && opcode == `FPP_OP_WRDI && bit_cnt == `FPP_BITS_OPCODE && !o_busy;

  ////////////////////////////////////////////////////////////////////////////
  // protection check of the framed address

  logic [23:0] addr_m;
  logic [10:0] sec;
  logic [10:0] blk_top;
  logic [10:0] blk_bot;
  logic        sec_prot;
  logic        blk_prot;
  logic        op_prot;

  assign addr_m  = addr_q & AMAX;
  assign sec     = addr_m[22:12] & PTR_MASK;
  assign blk_top = {sec[10:4], 4'hf};
  assign blk_bot = {sec[10:4], 4'h0};
  assign sec_prot = o_ptr_prot_en & (prot_all | (tb ? (sec < ptr) : (sec > ptr)));
  assign blk_prot = o_ptr_prot_en & (prot_all | (tb ? (blk_bot < ptr) : (blk_top > ptr)));
  assign op_prot  = (opcode == `FPP_OP_BE) ? blk_prot : sec_prot;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_op_start  <= 1'b0;
      o_op_reject <= 1'b0;
      o_op_code   <= 8'h00;
      o_op_addr   <= 24'h00_0000;
    end else begin
      o_op_start  <= arr_go && !op_prot;
      o_op_reject <= arr_go && op_prot;
      if (arr_go) begin
        o_op_code <= opcode;
        o_op_addr <= addr_m;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed pointer update

  fpp_pkg::fpp_nv_state_t nv_state;
  logic [11:0]            nv_cnt;
  logic [23:0]            stage;
  logic                   nv_done;
  assign nv_done = nv_state == fpp_pkg::FPP_NV_WRITE && nv_cnt == 12'h000;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      nv_state <= fpp_pkg::FPP_NV_IDLE;
      nv_cnt   <= 12'h000;
      stage    <= 24'h00_0000;
      o_busy   <= 1'b0;
    end else begin
      unique case (nv_state)
        fpp_pkg::FPP_NV_IDLE: begin
          if (setprot_go) begin
            nv_state <= fpp_pkg::FPP_NV_WRITE;
            nv_cnt   <= 12'(NV_CYC - 1);
            stage    <= addr_q;
            o_busy   <= 1'b1;
          end
        end
        fpp_pkg::FPP_NV_WRITE: begin
          if (nv_cnt == 12'h000) begin
            nv_state <= fpp_pkg::FPP_NV_IDLE;
            o_busy   <= 1'b0;
          end else begin
            nv_cnt <= nv_cnt - 12'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_block_prot_en <= 1'b1;
      o_ptr_prot_en   <= 1'b0;
      prot_all        <= 1'b0;
      ptr             <= 11'h000;
    end else if (nv_done) begin
      o_block_prot_en <= stage[`FPP_A_SCHEME];
      o_ptr_prot_en   <= ~stage[`FPP_A_SCHEME];
      if (!stage[`FPP_A_SCHEME]) begin
        prot_all <= stage[`FPP_A_ALL];
        ptr      <= stage[22:12] & PTR_MASK;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      write_enable_latch <= 1'b0;
    end else if (wren_go) begin
      write_enable_latch <= 1'b1;
    end else if (nv_done || wrdi_go || o_op_start) begin
      write_enable_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status-three and pointer read-back

  logic [31:0] tx;
  logic        rd_act;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !cs_low) begin
      tx     <= 32'hffff_ffff;
      rd_act <= 1'b0;
    end else if (sck_rise && bit_cnt == `FPP_BITS_OPCODE - 6'h01 && next_byte == `FPP_OP_RDSR3) begin
      tx     <= {sr3, ptr_addr[23:8], `FPP_ERASED_BYTE};
      rd_act <= 1'b1;
    end else if (sck_fall && rd_act) begin
      tx <= {tx[30:0], 1'b1};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_so    <= 1'b1;
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= rd_act && cs_low;
      if (sck_fall && rd_act) begin
        o_so <= tx[31];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sr1_hi  <= 6'(`FPP_SR1_RST >> 2);
      sr2     <= `FPP_SR2_RST;
      sr3     <= `FPP_SR3_RST;
      suspend <= 1'b0;
    end else if (i_wr) begin
      unique case (i_addr)
        `FPP_REG_SR1: begin
          if (!locked) begin
            sr1_hi <= i_wdata[7:2];
          end
        end
        `FPP_REG_SR2: begin
          if (!locked) begin
            sr2 <= i_wdata[7:0];
          end
        end
        `FPP_REG_SR3: begin
          sr3 <= i_wdata[7:0];
        end
        `FPP_REG_CTRL: begin
          suspend <= i_wdata[`FPP_CTRL_SUSP];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_addr)
        `FPP_REG_SR1:  o_rdata <= {24'h00_0000, sr1};
        `FPP_REG_SR2:  o_rdata <= {24'h00_0000, sr2};
        `FPP_REG_SR3:  o_rdata <= {24'h00_0000, sr3};
        `FPP_REG_PTR:  o_rdata <= {8'h00, ptr_addr};
        `FPP_REG_CTRL: o_rdata <= {30'h0000_0000, o_busy, suspend};
        `FPP_REG_FILL: o_rdata <= {24'h00_0000, `FPP_ERASED_BYTE};
        default:       o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [11:0] busy_len;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_busy) begin
      busy_len <= 12'h000;
    end else begin
      busy_len <= busy_len + 12'h001;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_scheme_excl: assert property (o_block_prot_en != o_ptr_prot_en)
    else $error("both protection schemes active");
  a_update_needs_wel: assert property ($rose(o_busy) |-> $past(write_enable_latch))
    else $error("pointer update without write enable");
  a_full_frame: assert property ($rose(o_busy) |-> $past(bit_cnt) == 6'h20 && $past(opcode) == 8'h39)
    else $error("pointer update from partial frame");
  a_lock_holds: assert property ($rose(o_busy) |-> !$past(locked))
    else $error("pointer update while status locked");
  a_no_suspend: assert property ($rose(o_busy) |-> !$past(suspend))
    else $error("pointer update during suspend");
  a_busy_length: assert property ($fell(o_busy) |-> $past(busy_len) == 12'(NV_CYC - 1))
    else $error("update time wrong");
  a_wel_cleared: assert property ($fell(o_busy) |-> !write_enable_latch)
    else $error("write enable not cleared after update");
  a_all_reject: assert property ((arr_go && o_ptr_prot_en && prot_all) |=> o_op_reject && !o_op_start)
    else $error("operation accepted while all protected");
  a_block_edge: assert property ((arr_go && opcode == 8'hd8 && o_ptr_prot_en && !prot_all && !tb
                                  && sec == ptr && ptr[3:0] != 4'hf) |=> o_op_reject)
    else $error("block erase over pointer sector accepted");
  a_ptr_sector: assert property ((arr_go && opcode == 8'h20 && sec == ptr) |=> !o_op_reject || $past(prot_all))
    else $error("pointer sector rejected");
  a_read_order: assert property ($rose(rd_act) |-> tx[31:8] == {sr3, ptr_addr[23:8]})
    else $error("status three read-back order wrong");
  c_update: cover property (o_busy && busy_len == 12'(NV_CYC - 1) ##1 !o_busy);
  c_reject: cover property (o_op_reject);
  c_accept: cover property (o_op_start && o_ptr_prot_en);
  c_readback: cover property ($rose(rd_act) ##[1:200] sck_fall);

endmodule

// ### tb/fpp_spi_host.sv
`timescale 1ns/100ps
module fpp_spi_host (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  // each serial clock level spans several reference cycles so the sampler sees it
  localparam int HALF = 6;

  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b1;
  end

  task automatic wait_ref(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one mode 0 frame, opcode then address msb first; rx collects reply bits
  task automatic xfer(input logic [47:0] bits, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_si <= bits[i];
      wait_ref(HALF);
      o_sck <= 1'b1;
      if (n - i > 8) begin
        rx = {rx[22:0], i_so};
      end
      wait_ref(HALF);
      o_sck <= 1'b0;
    end
    wait_ref(HALF);
    o_cs_n <= 1'b1;
    // released line shows the inverse of its last bit
    o_si <= ~o_si;
    wait_ref(8);
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [23:0] PA = {1'b1, 11'h2a5, 2'b00, 10'h3ff};
  localparam logic [10:0] PS = 11'h2a5;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        wp_n;
  logic [31:0] rdata;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        op_start;
  logic        op_reject;
  logic [7:0]  op_code;
  logic [23:0] op_addr;
  logic        blk_en;
  logic        ptr_en;
  logic        busy;
  logic [23:0] rx;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_start;
  int          n_rej;
  int          busy_cyc;
  int          n_oe;
  logic [7:0]  sr1_v = 8'h00;

  fpp_top #(.P_MBIT64(1'b1)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_so(so),
    .o_so_oe(so_oe), .o_op_start(op_start), .o_op_reject(op_reject), .o_op_code(op_code),
    .o_op_addr(op_addr), .o_block_prot_en(blk_en), .o_ptr_prot_en(ptr_en), .o_busy(busy)
  );

  fpp_spi_host host_u (.i_ref_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (op_start === 1'b1) n_start++;
    if (op_reject === 1'b1) n_rej++;
    if (busy === 1'b1) busy_cyc++;
    if (so_oe === 1'b1) n_oe++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(name, rdata, exp);
  endtask

  task automatic cmd(input logic [47:0] bits, input int n);
    host_u.xfer(bits, n, rx);
  endtask

  task automatic set_wel;
    cmd(48'h06, 8);
  endtask

  // set-protection frame of n bits; expects a timed update or none
  task automatic set_prot(input logic [23:0] a, input int n, input logic exp_busy);
    busy_cyc = 0;
    cmd({8'h39, a} >> (32 - n), n);
    if (exp_busy) begin
      rd_chk("busy_wel", 8'h00, {24'h0, sr1_v[7:2], 2'b11});
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
      if (busy !== 1'b0) begin
        n_mismatch++;
        give_verdict();
      end
      check("busy_len", busy_cyc, 2500);
      rd_chk("wel_clear", 8'h00, {24'h0, sr1_v[7:2], 2'b00});
    end else begin
      repeat (40) @(posedge clk);
      check("no_busy", busy_cyc, 0);
    end
  endtask

  task automatic do_op(input logic [7:0] op, input logic [10:0] sec, input logic ok);
    logic [23:0] a;
    a = {1'b1, sec, 12'h123};
    set_wel();
    n_start = 0;
    n_rej = 0;
    if (op == 8'h02) cmd({op, a, 8'h5a}, 40);
    else cmd({op, a}, 32);
    check("op_start", n_start, ok);
    check("op_reject", n_rej, !ok);
    if (ok) begin
      check("op_code", op_code, op);
      check("op_addr", op_addr, a & 24'h7fffff);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    wp_n = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk("sr1", 8'h00, 32'h00);
    rd_chk("sr2", 8'h04, 32'h04);
    rd_chk("sr3", 8'h08, 32'h70);
    rd_chk("fill", 8'h14, 32'hff);
    rd_chk("ptr_rst", 8'h0c, 32'h400);
    rd_chk("unmapped", 8'h20, 32'h0);
    check("prot_rst", {blk_en, ptr_en}, 2'b10);
    set_wel();
    set_prot(PA, 31, 1'b0);
    cmd(48'h04, 8);
    set_prot(PA, 32, 1'b0);
    set_wel();
    reg_wr(8'h10, 32'h1);
    set_prot(PA, 32, 1'b0);
    reg_wr(8'h10, 32'h0);
    set_wel();
    set_prot(PA, 32, 1'b1);
    check("prot_ptr", {blk_en, ptr_en}, 2'b01);
    rd_chk("ptr", 8'h0c, {9'h0, PS, 12'h000});
    n_oe = 0;
    cmd({8'h33, 24'h0}, 32);
    check("rd_ptr", rx, {8'h70, 1'b0, PS, 4'h0});
    check("so_oe", {n_oe != 0, so_oe}, 2'b10);
    do_op(8'h02, PS, 1'b1);
    do_op(8'h20, PS, 1'b1);
    do_op(8'h02, PS + 11'h1, 1'b0);
    do_op(8'h20, PS - 11'h1, 1'b1);
    do_op(8'h20, 11'h7ff, 1'b0);
    do_op(8'hd8, PS, 1'b0);
    do_op(8'hd8, 11'h290, 1'b1);
    reg_wr(8'h00, 32'h20);
    sr1_v = 8'h20;
    rd_chk("sr1_tb", 8'h00, 32'h20);
    do_op(8'h02, PS, 1'b1);
    do_op(8'h02, PS - 11'h1, 1'b0);
    do_op(8'h20, PS + 11'h1, 1'b1);
    do_op(8'hd8, PS, 1'b0);
    do_op(8'h20, 11'h000, 1'b0);
    set_wel();
    set_prot({1'b0, 11'h2a0, 12'h000}, 32, 1'b1);
    do_op(8'hd8, 11'h2a0, 1'b1);
    set_wel();
    set_prot(24'h000800, 32, 1'b1);
    do_op(8'h02, 11'h000, 1'b0);
    do_op(8'h02, 11'h7ff, 1'b0);
    set_wel();
    set_prot(24'h000400, 32, 1'b1);
    check("prot_blk", {blk_en, ptr_en}, 2'b10);
    do_op(8'h02, 11'h7ff, 1'b1);
    reg_wr(8'h00, 32'ha0);
    sr1_v = 8'ha0;
    wp_n <= 1'b0;
    set_wel();
    set_prot(PA, 32, 1'b0);
    check("prot_wp", {blk_en, ptr_en}, 2'b10);
    wp_n <= 1'b1;
    repeat (8) @(posedge clk);
    reg_wr(8'h04, 32'h01);
    set_wel();
    set_prot(PA, 32, 1'b0);
    check("prot_lock", {blk_en, ptr_en}, 2'b10);
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
